// >>> hw/sef_spi_frame.v
// bit level framing for a serial eeprom four-wire interface
`timescale 1ns/10ps
`include "sef_map.vh"
module sef_spi_frame
(
    input wire ref_clk,
    input wire rstn,
    input wire cs_n,
    input wire sck,
    input wire si,
    input wire hold_n,
    input wire wp_n,
    input wire protect_pin_enable_bit,
    input wire [7:0] tx_byte,
    output reg so_o,
    output reg so_oe,
    output reg [7:0] rx_byte,
    output reg rx_valid,
    output reg tx_take,
    output reg opcode_valid,
    output reg [7:0] opcode,
    output reg status_write_block
);
    // two-flop synchronisers, one per pin
    reg [1:0] cs_s_q;
    reg [1:0] sck_s_q;
    reg [1:0] si_s_q;
    reg [1:0] hold_s_q;
    reg [1:0] wp_s_q;
    // serial clock history for edge finding
    reg sck_prev_q;
    // bit and byte position inside the frame
    reg [2:0] bit_cnt_q;
    reg [3:0] byte_cnt_q;
    // shift registers in and out
    reg [7:0] sh_in_q;
    reg [7:0] sh_out_q;
    // pause state, kept until resume with clock low
    reg paused_q;
    // edge detect reads only the second sync stage
    wire cs_act = ~cs_s_q[1];
    wire sck_now = sck_s_q[1];
    wire rise = sck_now & ~sck_prev_q;
    wire fall = ~sck_now & sck_prev_q;
    wire [7:0] in_next = {sh_in_q[6:0], si_s_q[1]};
    // output drives only once the opcode byte is past
    function data_phase;
        input [3:0] cnt;
        begin
            data_phase = (cnt != `SEF_BYTE_FIRST);
        end
    endfunction
    // chip select sync, idles deselected
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cs_s_q <= `SEF_SYNC_HIGH;
        end
        else
        begin
            cs_s_q <= {cs_s_q[0], cs_n};
        end
    end
    // serial clock sync, idles low
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sck_s_q <= `SEF_SYNC_LOW;
        end
        else
        begin
            sck_s_q <= {sck_s_q[0], sck};
        end
    end
    // serial input sync
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            si_s_q <= `SEF_SYNC_LOW;
        end
        else
        begin
            si_s_q <= {si_s_q[0], si};
        end
    end
    // pause pin sync, idles released
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hold_s_q <= `SEF_SYNC_HIGH;
        end
        else
        begin
            hold_s_q <= {hold_s_q[0], hold_n};
        end
    end
    // write-protect pin sync, idles released
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wp_s_q <= `SEF_SYNC_HIGH;
        end
        else
        begin
            wp_s_q <= {wp_s_q[0], wp_n};
        end
    end
    // framing: shift in on rising, out on falling
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sck_prev_q <= 1'b0;
            bit_cnt_q <= `SEF_BIT_FIRST;
            byte_cnt_q <= `SEF_BYTE_FIRST;
            sh_in_q <= `SEF_BYTE_RST;
            sh_out_q <= `SEF_BYTE_RST;
            paused_q <= 1'b0;
            so_o <= 1'b0;
            so_oe <= 1'b0;
            rx_byte <= `SEF_BYTE_RST;
            rx_valid <= 1'b0;
            tx_take <= 1'b0;
            opcode_valid <= 1'b0;
            opcode <= `SEF_BYTE_RST;
            status_write_block <= 1'b0;
        end
        else
        begin
            sck_prev_q <= sck_now;
            rx_valid <= 1'b0;
            tx_take <= 1'b0;
            status_write_block <= protect_pin_enable_bit & ~wp_s_q[1];
            if (!cs_act)
            begin
                bit_cnt_q <= `SEF_BIT_FIRST;
                byte_cnt_q <= `SEF_BYTE_FIRST;
                paused_q <= 1'b0;
                so_oe <= 1'b0;
                opcode_valid <= 1'b0;
                sh_out_q <= tx_byte;
            end
            else if (!hold_s_q[1])
            begin
                paused_q <= 1'b1;
                so_oe <= 1'b0;
            end
            else if (paused_q)
            begin
                if (!sck_now)
                begin
                    paused_q <= 1'b0;
                    so_oe <= data_phase(byte_cnt_q);
                end
            end
            else
            begin
                if (rise)
                begin
                    sh_in_q <= in_next;
                    bit_cnt_q <= bit_cnt_q + `SEF_BIT_STEP;
                    if (bit_cnt_q == `SEF_BIT_LAST)
                    begin
                        rx_byte <= in_next;
                        rx_valid <= 1'b1;
                        // byte count saturates, no wrap to opcode
                        if (byte_cnt_q != `SEF_BYTE_SAT)
                            byte_cnt_q <= byte_cnt_q + `SEF_BYTE_STEP;
                        if (!data_phase(byte_cnt_q))
                        begin
                            opcode <= in_next;
                            opcode_valid <= 1'b1;
                        end
                    end
                end
                if (fall)
                begin
                    so_oe <= data_phase(byte_cnt_q);
                    // byte boundary: load the next byte to send
                    if (bit_cnt_q == `SEF_BIT_FIRST)
                    begin
                        so_o <= tx_byte[7];
                        sh_out_q <= {tx_byte[6:0], 1'b0};
                        tx_take <= 1'b1;
                    end
                    else
                    begin
                        so_o <= sh_out_q[7];
                        sh_out_q <= {sh_out_q[6:0], 1'b0};
                    end
                end
            end
        end
    end
endmodule

// >>> hw/sef_map.vh
// bit framing constants for the serial eeprom front end
`ifndef SEF_MAP_VH
`define SEF_MAP_VH
`define SEF_OPC_WRSR 8'h01
`define SEF_OPC_RDSR 8'h05
`define SEF_OPC_READ 8'h03
`define SEF_OPC_WRITE 8'h02
`define SEF_BITS_BYTE 4'h8
`define SEF_CNT_RST 5'h00
`define SEF_BYTE_RST 8'h00
`define SEF_BIT_FIRST 3'h0
`define SEF_BIT_LAST 3'h7
`define SEF_BIT_STEP 3'h1
`define SEF_BYTE_FIRST 4'h0
`define SEF_BYTE_SAT 4'hF
`define SEF_BYTE_STEP 4'h1
`define SEF_SYNC_HIGH 2'h3
`define SEF_SYNC_LOW 2'h0
`endif

// >>> verification/sef_spi_frame_monitor.sv
// port assertions for the spi framing block
`timescale 1ns/10ps
module sef_spi_frame_monitor (input wire ref_clk, input wire rstn,
    input wire cs_n, input wire sck, input wire hold_n, input wire wp_n,
    input wire protect_pin_enable_bit, input wire so_o, input wire so_oe,
    input wire rx_valid, input wire status_write_block);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    wp_lock_a: assert property ((protect_pin_enable_bit & !wp_n) [*4]
        |-> status_write_block) else $error("open");
    wp_free_a: assert property (!protect_pin_enable_bit [*4]
        |-> !status_write_block) else $error("shut");
    sel_off_a: assert property (cs_n [*4] |-> !so_oe) else $error("on");
    hold_z_a: assert property (!hold_n [*4] |-> !so_oe) else $error("z");
    hold_rx_a: assert property (!hold_n [*4] |-> !rx_valid)
        else $error("rx");
    fall_so_a: assert property (!cs_n && $changed(so_o) |->
        !$past(sck, 2)) else $error("rise");
    rise_si_a: assert property (rx_valid |-> $past(sck, 2))
        else $error("fall");
    rx_one_a: assert property (rx_valid |=> !rx_valid) else $error("two");
endmodule
bind sef_spi_frame sef_spi_frame_monitor mon_u (.*);

// >>> verification/sef_host.sv
// spi host model: select, clock, data, pause
`timescale 1ns/10ps
module sef_host (input wire ref_clk, input wire so_o, output reg cs_n = 1'h1,
    output reg sck = 1'h0, output reg si = 1'h0, output reg hold_n = 1'h1,
    output reg [7:0] got = 8'h00);
    // 16 bits msb first, so read after each rise, optional pause
    task frame(input [15:0] w, input m, input p);
        cs_n <= 1'h1;
        sck <= m;
        si <= ~si;
        repeat (8) @(posedge ref_clk);
        cs_n <= 1'h0;
        for (int i = 15; i >= 0; i = i - 1)
        begin
            repeat (2) @(posedge ref_clk);
            sck <= 1'h0;
            si <= w[i];
            repeat (2) @(posedge ref_clk);
            hold_n <= !(p && i == 4);
            repeat (p && i == 4 ? 16 : 2) @(posedge ref_clk);
            hold_n <= 1'h1;
            repeat (p && i == 4 ? 4 : 0) @(posedge ref_clk);
            sck <= 1'h1;
            repeat (2) @(posedge ref_clk);
            got <= {got[6:0], so_o};
        end
        repeat (4) @(posedge ref_clk);
    endtask
endmodule

// >>> verification/sef_spi_frame_bench.sv
// self-checking bench for the spi framing block
`timescale 1ns/10ps
module sef_spi_frame_bench;
    reg ref_clk = 1'h0, rstn = 1'h0, wp_n = 1'h1;
    reg protect_pin_enable_bit = 1'h0;
    reg [7:0] tx_byte = 8'h00, op, d;
    wire cs_n, sck, si, hold_n, so_o, so_oe, rx_valid, tx_take, opcode_valid;
    wire status_write_block;
    wire [7:0] rx_byte, opcode, got;
    integer bad_count = 0, compares = 0, seed = 4242, k;
    // clock, block and host
    always #10 ref_clk = ~ref_clk;
    sef_spi_frame dut_u (.*);
    sef_host host_u (.*);
    task chk(input [15:0] s, input [15:0] e);
        compares = compares + 1;
        bad_count = bad_count + (s !== e);
        if (s !== e)
            $display("[ERR] %0t got %h want %h", $time, s, e);
    endtask
    task print_verdict(input integer late);
        bad_count = bad_count + late;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // watchdog far past eight frames
    initial #100000 print_verdict(1);
    // random frames in both modes, one paused, last hand made
    initial
    begin
        repeat (10) @(posedge ref_clk);
        rstn <= 1'h1;
        for (k = 0; k < 8; k = k + 1)
        begin
            {op, d} = (k == 7) ? 16'h01FF : 16'($random(seed));
            tx_byte <= 8'($random(seed));
            {wp_n, protect_pin_enable_bit} <= d[1:0];
            host_u.frame({op, d}, k[0], k == 5);
            chk({opcode, rx_byte}, {op, d});
            chk({8'h00, got}, {8'h00, tx_byte});
            chk({15'h0000, opcode_valid}, 16'h0001);
            chk({15'h0000, so_oe}, 16'h0001);
            chk({15'h0000, status_write_block}, {15'h0000, d[0] & ~d[1]});
            $display("frame %0d done", k);
        end
        print_verdict(0);
    end
endmodule
